// ### hw/acot_top.sv
/*
  Amplifier control and offset trim block: control register (supply
  rail, enable, bandwidth, output status) and offset trim register
  (mode, reference input, 6-bit trim code), reached over Avalon-MM.
  Assumes a synchronous active-low reset, a 20 MHz clock, an
  asynchronous comparator-style amplifier output, and software that
  runs the trim sweeps itself.
*/
// The address map and register access over Avalon-MM are this design's own decisions.
// Behaviour
// [RULE1] Control bit 7 picks supply rail
// [RULE2] Control bit 6 enables the amplifier
// [RULE3] Bit 5 reads output level, calibration only
// [RULE4] Bits 4 to 2 ignore writes, read zero
// [RULE5] Low two bits select amplifier bandwidth
// [RULE6] Software pairs bandwidth with converter clock
// [RULE7] Trim bit 7 selects calibration mode
// [RULE8] Trim bit 6 selects calibration reference pin
// [RULE9] Low six trim bits hold trim code
// [RULE10] Software enables amplifier before calibration mode
// [RULE11] Software sweeps trim code upward from zero
// [RULE12] Software sweeps trim code downward from ones
// [RULE13] Software stores bounds midpoint, truncated
// [RULE14] Amplifier output passes two-flop synchroniser
`timescale 1ns/1ps
`include "acot_consts.svh"

module acot_top
  import acot_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [1:0]       o_avs_response,
  input  wire logic        i_amp_output_level,
  output acot_analog_t     o_analog
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic       pwr_sel_r;
  logic       amp_en_r;
  acot_bw_t   bw_r;
  logic       cal_mode_r;
  logic       cal_ref_r;
  logic [5:0] trim_code_r;
  logic       out_sync;
  logic       out_status;
  logic       accept;
  logic       hit_ctl;
  logic       hit_trim;
  logic       wr_low;
  logic [7:0] ctl_view;
  logic [7:0] trim_view;
  logic [31:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Amplifier output capture
  // ----------------------------------------------------------------
  // Raw comparator level toggles freely, so sample it twice first
  acot_sync2 u_sync
  (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    (i_amp_output_level),
    .o_sync     (out_sync)
  ); // RULE14

  // Status reads zero outside calibration so normal mode sees no noise
  assign out_status = cal_mode_r & out_sync; // RULE3

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  acot_waitgen u_wait
  (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_req      (i_avs_read | i_avs_write),
    .o_accept   (accept)
  );

  assign hit_ctl  = (i_avs_address == `ACOT_OFS_CONTROL);
  assign hit_trim = (i_avs_address == `ACOT_OFS_TRIM);
  // Registers are 8 bits wide, so only byte lane 0 writes them
  assign wr_low   = accept & i_avs_write & i_avs_byteenable[0];

  // Read views; bits 4..2 of control are constant zero
  assign ctl_view  = {pwr_sel_r, amp_en_r, out_status, 3'h0, bw_r}; // RULE4
  assign trim_view = {cal_mode_r, cal_ref_r, trim_code_r}; // RULE9

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctl)
      rdata_nxt = {24'h00_0000, ctl_view};
    else if (hit_trim)
      rdata_nxt = {24'h00_0000, trim_view};
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Bits 5..2 are never stored; the read-only status cannot be written
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pwr_sel_r <= 1'b0;
      amp_en_r  <= 1'b0;
      bw_r      <= ACOT_BW_5KHZ;
    end
    else if (wr_low && hit_ctl)
    begin
      pwr_sel_r <= i_avs_writedata[`ACOT_CTL_PWR_BIT]; // RULE1
      amp_en_r  <= i_avs_writedata[`ACOT_CTL_EN_BIT]; // RULE2
      bw_r      <= acot_bw_t'(i_avs_writedata[`ACOT_CTL_BW_HI:`ACOT_CTL_BW_LO]); // RULE5
    end
  end

  // ----------------------------------------------------------------
  // Offset trim register
  // ----------------------------------------------------------------
  // Software owns the sweep; hardware only applies the code it writes
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      cal_mode_r  <= 1'(`ACOT_TRIM_RESET >> `ACOT_TRIM_MODE_BIT);
      cal_ref_r   <= 1'(`ACOT_TRIM_RESET >> `ACOT_TRIM_REF_BIT);
      trim_code_r <= 6'(`ACOT_TRIM_RESET);
    end
    else if (wr_low && hit_trim)
    begin
      cal_mode_r  <= i_avs_writedata[`ACOT_TRIM_MODE_BIT]; // RULE7
      cal_ref_r   <= i_avs_writedata[`ACOT_TRIM_REF_BIT]; // RULE8
      trim_code_r <= i_avs_writedata[`ACOT_TRIM_CODE_HI:`ACOT_TRIM_CODE_LO]; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Read data registered with the accept so it stands when waitrequest drops
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_avs_readdata    <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
      o_avs_response    <= 2'h0;
    end
    else
    begin
      o_avs_waitrequest <= ~accept;
      if (accept)
      begin
        o_avs_readdata <= i_avs_read ? rdata_nxt : 32'h0000_0000;
        // Unmapped offsets answer with a decode error
        o_avs_response <= (hit_ctl | hit_trim) ? 2'h0 : 2'h3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_analog <= '0;
    else
    begin
      o_analog.power_switch_two_select      <= pwr_sel_r; // RULE1
      o_analog.amp_enable                   <= amp_en_r; // RULE2
      o_analog.amp_bandwidth_select         <= bw_r; // RULE5
      o_analog.calibration_mode_select      <= cal_mode_r; // RULE7
      o_analog.calibration_reference_select <= cal_ref_r; // RULE8
      o_analog.offset_trim_code             <= trim_code_r; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PWR_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_low && hit_ctl |-> ##2 o_analog.power_switch_two_select == $past(i_avs_writedata[7], 2))
    else $error("Supply select not driven from write"); // RULE1

  AST_EN_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_low && hit_ctl |-> ##2 o_analog.amp_enable == $past(i_avs_writedata[6], 2))
    else $error("Enable not driven from write"); // RULE2

  AST_STATUS_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !cal_mode_r |-> ctl_view[5] == 1'b0)
    else $error("Status bit set outside calibration"); // RULE3

  AST_STATUS_CAL: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cal_mode_r && $stable(cal_mode_r) |-> ctl_view[5] == $past(u_sync.meta_r))
    else $error("Status does not follow synchronised output"); // RULE3

  AST_UNIMPL_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    accept && i_avs_read && hit_ctl |=> o_avs_readdata[4:2] == 3'h0)
    else $error("Unimplemented bits read nonzero"); // RULE4

  AST_BW_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_low && hit_ctl |-> ##2 o_analog.amp_bandwidth_select == $past(i_avs_writedata[1:0], 2))
    else $error("Bandwidth not driven from write"); // RULE5

  AST_MODE_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_low && hit_trim |-> ##2 o_analog.calibration_mode_select == $past(i_avs_writedata[7], 2))
    else $error("Mode not driven from write"); // RULE7

  AST_REF_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_low && hit_trim |-> ##2 o_analog.calibration_reference_select == $past(i_avs_writedata[6], 2))
    else $error("Reference not driven from write"); // RULE8

  AST_TRIM_READBACK: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    accept && i_avs_read && hit_trim |=> o_avs_readdata[5:0] == $past(trim_code_r))
    else $error("Trim code readback mismatch"); // RULE9

  AST_SYNC_DELAY: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(i_amp_output_level) ##1 i_amp_output_level |=> out_sync)
    else $error("Synchroniser latency wrong"); // RULE14

endmodule

// ### hw/acot_consts.svh
/*
  Offsets, field positions, reset values and bus timing for the amplifier
  control and offset trim block.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef ACOT_CONSTS_SVH
`define ACOT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define ACOT_OFS_CONTROL      4'h0
`define ACOT_OFS_TRIM         4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ACOT_CTL_PWR_BIT      7
`define ACOT_CTL_EN_BIT       6
`define ACOT_CTL_OUT_BIT      5
`define ACOT_CTL_BW_HI        1
`define ACOT_CTL_BW_LO        0
`define ACOT_CTL_RESET        8'h00

// ----------------------------------------------------------------
// Trim register fields
// ----------------------------------------------------------------
`define ACOT_TRIM_MODE_BIT    7
`define ACOT_TRIM_REF_BIT     6
`define ACOT_TRIM_CODE_HI     5
`define ACOT_TRIM_CODE_LO     0
`define ACOT_TRIM_RESET       8'h20

// ----------------------------------------------------------------
// Bus timing: wait states inserted before each answer
// ----------------------------------------------------------------
`define ACOT_WAIT_CYCLES      2'h1

`endif

// ### hw/acot_pkg.sv
/*
  Types for the amplifier control and offset trim block.
  Assumes acot_consts.svh on the include path.
*/
`include "acot_consts.svh"

package acot_pkg;

  // Bandwidth codes of the amplifier
  typedef enum logic [1:0]
  {
    ACOT_BW_5KHZ   = 2'h0,
    ACOT_BW_40KHZ  = 2'h1,
    ACOT_BW_600KHZ = 2'h2,
    ACOT_BW_2MHZ   = 2'h3
  } acot_bw_t;

  // Settings driven to the analog amplifier
  typedef struct packed
  {
    logic       power_switch_two_select;
    logic       amp_enable;
    acot_bw_t   amp_bandwidth_select;
    logic       calibration_mode_select;
    logic       calibration_reference_select;
    logic [5:0] offset_trim_code;
  } acot_analog_t;

  // Bus handshake states
  typedef enum
  {
    ACOT_ST_IDLE,
    ACOT_ST_WAIT,
    ACOT_ST_DONE
  } acot_state_t;

endpackage

// ### hw/acot_sync2.sv
/*
  Two-flop level synchroniser.
  Assumes an asynchronous level input and one system clock.
*/
`timescale 1ns/1ps

module acot_sync2
  import acot_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_r;

  // ----------------------------------------------------------------
  // Two stages; the first is read by the second only
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ### hw/acot_waitgen.sv
/*
  Wait-state sequencer for the Avalon-MM slave: holds waitrequest high
  for a fixed number of cycles, then lets one access complete.
  Assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/1ps
`include "acot_consts.svh"

module acot_waitgen
  import acot_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_req,
  output logic      o_accept
);

  acot_state_t state_r;
  logic [1:0]  cnt_r;

  // ----------------------------------------------------------------
  // Request sequencing; DONE gives one idle cycle so the master can drop
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      state_r <= ACOT_ST_IDLE;
      cnt_r   <= 2'h0;
    end
    else
    begin
      case (state_r)
        ACOT_ST_IDLE:
        begin
          cnt_r <= 2'h0;
          if (i_req)
            state_r <= ACOT_ST_WAIT;
        end
        ACOT_ST_WAIT:
        begin
          if (cnt_r == `ACOT_WAIT_CYCLES)
            state_r <= ACOT_ST_DONE;
          else
            cnt_r <= cnt_r + 2'h1;
        end
        ACOT_ST_DONE:
          state_r <= ACOT_ST_IDLE;
        default:
          state_r <= ACOT_ST_IDLE;
      endcase
    end
  end

  // Accept is the cycle before the one in which the slave holds waitrequest low
  assign o_accept = (state_r == ACOT_ST_WAIT) && (cnt_r == `ACOT_WAIT_CYCLES);

endmodule

// ### sim/acot_amp_model.sv
/*
  Behavioural model of the sensing amplifier as seen from its trim input:
  a comparator whose flip point sits at a fixed trim code.
  Assumes the settings struct of the control block drives it directly.
*/
`timescale 1ns/1ps

module acot_amp_model
  import acot_pkg::*;
#(
  parameter logic [5:0] THRESHOLD = 6'h1B
)
(
  input  wire acot_analog_t i_analog,
  output logic              o_level
);
  // -------------------------------------------------------------
  // Output level
  // -------------------------------------------------------------
  // A disabled amplifier pulls its output low; the reference pin choice
  // turns the polarity round, so a sweep sees a flip either way
  always_comb
  begin
    if (!i_analog.amp_enable)
      o_level = 1'b0;
    else
      o_level = (i_analog.offset_trim_code >= THRESHOLD)
                ~^ i_analog.calibration_reference_select;
  end
endmodule

// ### sim/acot_tb.sv
/*
  Self-checking bench for the amplifier control and offset trim block.
  Assumes the design sources in hw/ and the amplifier model in sim/.
*/
`timescale 1ns/1ps
`include "acot_consts.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end

module testbench
  import acot_pkg::*;
;
  localparam logic [5:0] THR    = 6'h1B;
  localparam logic [5:0] THR_M1 = THR - 6'h01;
  localparam int         MID    = (2 * int'(THR) - 1) / 2;

  logic         core_clk = 1'b0;
  logic         reset_n  = 1'b0;
  logic         rd_req   = 1'b0;
  logic         wr_req   = 1'b0;
  logic [3:0]   addr     = 4'h0;
  logic [3:0]   be       = 4'hF;
  logic [31:0]  wdata    = 32'h0;
  logic [31:0]  rdata;
  logic         wait_req;
  logic [1:0]   resp;
  logic         amp_level;
  acot_analog_t analog;
  logic [31:0]  got;
  logic [1:0]   gresp;
  int           n_fail   = 0;
  int           n_checks = 0;

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  acot_top i_acot_top (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_avs_address(addr),
    .i_avs_read(rd_req), .i_avs_write(wr_req), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .o_avs_response(resp), .i_amp_output_level(amp_level), .o_analog(analog));

  acot_amp_model #(.THRESHOLD(THR)) i_acot_amp_model (.i_analog(analog), .o_level(amp_level));

  // -------------------------------------------------------------
  // Bus helpers
  // -------------------------------------------------------------
  // Holds the request until waitrequest is sampled low; bounded so a
  // stuck slave ends as a mismatch rather than a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int t;
    t = 0;
    @(posedge core_clk);
    rd_req <= ~w;
    wr_req <= w;
    addr   <= a;
    wdata  <= {24'h0, d};
    be     <= b;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (wait_req !== 1'b0 && t < 50);
    got    = rdata;
    gresp  = resp;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    `CHK("bus answer", 1'b1, t < 50)
  endtask

  // Lets register, amplifier and synchroniser settle after a write
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic status(output logic s);
    bus(1'b0, `ACOT_OFS_CONTROL, 8'h00, 4'hF);
    s = got[5];
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, `ACOT_OFS_CONTROL, 8'h00, 4'hF);
    `CHK("ctl reset", 32'h0, got)
    `CHK("resp ok", 2'h0, gresp)
    bus(1'b0, `ACOT_OFS_TRIM, 8'h00, 4'hF);
    `CHK("trim reset", 32'h20, got)
    `CHK("analog reset", 12'h020, analog)
    $display("test reset done");
  endtask

  task automatic t_control;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = {i[0], ~i[0], 4'hF, i[1:0]};
      bus(1'b1, `ACOT_OFS_CONTROL, d, 4'hF);
      settle(1);
      `CHK("pwr", d[7], analog.power_switch_two_select)
      `CHK("en", d[6], analog.amp_enable)
      `CHK("bw", d[1:0], analog.amp_bandwidth_select)
      bus(1'b0, `ACOT_OFS_CONTROL, 8'h00, 4'hF);
      `CHK("ctl read", {24'h0, d & 8'hC3}, got)
    end
    // Lane 0 disabled and unmapped accesses must leave state alone
    bus(1'b1, `ACOT_OFS_CONTROL, 8'h00, 4'h0);
    bus(1'b0, `ACOT_OFS_CONTROL, 8'h00, 4'hF);
    `CHK("lane off", 32'h83, got)
    bus(1'b1, 4'h8, 8'hFF, 4'hF);
    bus(1'b0, 4'h8, 8'h00, 4'hF);
    `CHK("unmapped resp", 2'h3, gresp)
    `CHK("unmapped data", 32'h0, got)
    bus(1'b0, `ACOT_OFS_TRIM, 8'h00, 4'hF);
    `CHK("trim kept", 32'h20, got)
    $display("test control done");
  endtask

  task automatic t_trim;
    logic s;
    bus(1'b1, `ACOT_OFS_CONTROL, 8'h40, 4'hF);
    bus(1'b1, `ACOT_OFS_TRIM, 8'h7F, 4'hF);
    settle(4);
    `CHK("mode", 1'b0, analog.calibration_mode_select)
    `CHK("ref", 1'b1, analog.calibration_reference_select)
    `CHK("code", 6'h3F, analog.offset_trim_code)
    status(s);
    `CHK("status normal", 1'b0, s)
    bus(1'b1, `ACOT_OFS_TRIM, 8'hFF, 4'hF);
    settle(4);
    `CHK("mode cal", 1'b1, analog.calibration_mode_select)
    status(s);
    `CHK("status high", 1'b1, s)
    bus(1'b1, `ACOT_OFS_TRIM, 8'hBF, 4'hF);
    settle(4);
    status(s);
    `CHK("status ref", 1'b0, s)
    bus(1'b0, `ACOT_OFS_TRIM, 8'h00, 4'hF);
    `CHK("trim read", 32'hBF, got)
    $display("test trim done");
  endtask

  // Software sweep up from zero, down from all ones, store the midpoint
  task automatic t_cal;
    logic       s0;
    logic       s;
    logic [5:0] c;
    logic [5:0] v1;
    logic [6:0] sum;
    bus(1'b1, `ACOT_OFS_CONTROL, 8'h40, 4'hF);
    bus(1'b1, `ACOT_OFS_TRIM, 8'hC0, 4'hF);
    settle(4);
    status(s0);
    c = 6'h00;
    s = s0;
    while (s === s0 && c != 6'h3F)
    begin
      c++;
      bus(1'b1, `ACOT_OFS_TRIM, {2'b11, c}, 4'hF);
      settle(4);
      status(s);
    end
    v1 = c;
    `CHK("up bound", THR, v1)
    c = 6'h3F;
    bus(1'b1, `ACOT_OFS_TRIM, 8'hFF, 4'hF);
    settle(4);
    status(s0);
    s = s0;
    while (s === s0 && c != 6'h00)
    begin
      c--;
      bus(1'b1, `ACOT_OFS_TRIM, {2'b11, c}, 4'hF);
      settle(4);
      status(s);
    end
    `CHK("down bound", THR_M1, c)
    sum = {1'b0, v1} + {1'b0, c};
    bus(1'b1, `ACOT_OFS_TRIM, {2'b11, sum[6:1]}, 4'hF);
    bus(1'b0, `ACOT_OFS_TRIM, 8'h00, 4'hF);
    `CHK("midpoint", {24'h0, 2'b11, 6'(MID)}, got)
    $display("test calibration done");
  endtask

  // -------------------------------------------------------------
  // Verdict and run control
  // -------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is about a thousand cycles; this margin is far above it
  initial
  begin
    #2_000_000;
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_control();
    t_trim();
    t_cal();
    close_out();
  end
endmodule
